//--- src/pulse_timebase.sv
module pulse_timebase #(
   parameter int TICK_CYCLES = single_pulse_pkg::BASE_TICK_CYC
) (
   input  wire logic i_clk,
   input  wire logic i_reset_n,
   input  wire logic i_restart,
   output logic      o_tick
);

   localparam logic [single_pulse_pkg::TICK_W-1:0] RELOAD =
      single_pulse_pkg::TICK_W'(TICK_CYCLES - 1);

   logic [single_pulse_pkg::TICK_W-1:0] cnt_q;
   logic [single_pulse_pkg::TICK_W-1:0] cnt_d;

   // Down counter; restart realigns phase so no tick error accrues
   always_comb begin
      if (i_restart || cnt_q == '0) begin
         cnt_d = RELOAD;
      end else begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         cnt_q <= RELOAD;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign o_tick = (cnt_q == '0);

endmodule : pulse_timebase

//--- src/single_pulse_pkg.sv
package single_pulse_pkg;

   // Clock and base timebase
   localparam int CLK_PERIOD_NS  = 40;
   localparam int BASE_TICK_US   = 10000;   // One hundredth of a second
   localparam int BASE_TICK_CYC  = (BASE_TICK_US * 1000) / CLK_PERIOD_NS;
   localparam int TICK_W         = 18;

   // Duration setting, in hundredths of the selected unit
   localparam int          DUR_W   = 14;
   localparam logic [13:0] DUR_MIN = 14'h0001;   // 0.01
   localparam logic [13:0] DUR_MAX = 14'h270f;   // 99.99

   // Base ticks per hundredth of each unit
   localparam int          MULT_W    = 12;
   localparam logic [11:0] MULT_SEC  = 12'h001;  // 10 ms
   localparam logic [11:0] MULT_MIN  = 12'h03c;  // 600 ms
   localparam logic [11:0] MULT_HOUR = 12'he10;  // 36 s

   // Unit select codes
   typedef enum logic [1:0] {
      UNIT_SEC  = 2'h0,
      UNIT_MIN  = 2'h1,
      UNIT_HOUR = 2'h2
   } unit_t;

   // Pulse states, one-hot
   typedef enum logic [1:0] {
      ST_IDLE  = 2'h1,
      ST_PULSE = 2'h2
   } pulse_state_t;

endpackage : single_pulse_pkg

//--- src/single_pulse_relay_block.sv
module single_pulse_relay_block #(
   parameter int TICK_CYCLES = single_pulse_pkg::BASE_TICK_CYC
) (
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_pulse_trigger,
   input  wire logic        i_clear,
   input  wire logic [13:0] i_duration,
   input  wire logic [1:0]  i_unit,
   output logic             o_pulse,
   output logic             o_busy
);

   single_pulse_pkg::pulse_state_t state_q;
   single_pulse_pkg::pulse_state_t state_d;

   logic [1:0]                            trg_sync_q;
   logic [1:0]                            trg_sync_d;
   logic                                  trg_prev_q;
   logic                                  trg_prev_d;
   logic [1:0]                            clr_sync_q;
   logic [1:0]                            clr_sync_d;
   logic [single_pulse_pkg::DUR_W-1:0]    remain_q;
   logic [single_pulse_pkg::DUR_W-1:0]    remain_d;
   logic [single_pulse_pkg::MULT_W-1:0]   sub_q;
   logic [single_pulse_pkg::MULT_W-1:0]   sub_d;
   logic [single_pulse_pkg::MULT_W-1:0]   mult_q;
   logic [single_pulse_pkg::MULT_W-1:0]   mult_d;
   logic                                  pulse_q;
   logic                                  pulse_d;
   logic                                  trg_rise;
   logic                                  clr_lvl;
   logic                                  start;
   logic                                  tick;

   // Base ticks per hundredth of the chosen unit; spare code means seconds
   function automatic logic [single_pulse_pkg::MULT_W-1:0] unit_mult(
      input logic [1:0] unit
   );
      unique case (unit)
         single_pulse_pkg::UNIT_MIN:  unit_mult = single_pulse_pkg::MULT_MIN;
         single_pulse_pkg::UNIT_HOUR: unit_mult = single_pulse_pkg::MULT_HOUR;
         default:                     unit_mult = single_pulse_pkg::MULT_SEC;
      endcase
   endfunction : unit_mult

   // Out-of-range settings are pulled into the legal span
   function automatic logic [single_pulse_pkg::DUR_W-1:0] clamp_dur(
      input logic [13:0] dur
   );
      if (dur < single_pulse_pkg::DUR_MIN) begin
         clamp_dur = single_pulse_pkg::DUR_MIN;
      end else if (dur > single_pulse_pkg::DUR_MAX) begin
         clamp_dur = single_pulse_pkg::DUR_MAX;
      end else begin
         clamp_dur = dur;
      end
   endfunction : clamp_dur

   // Pins are asynchronous; two stages before any logic looks
   always_comb begin
      trg_sync_d = {trg_sync_q[0], i_pulse_trigger};
      clr_sync_d = {clr_sync_q[0], i_clear};
      trg_prev_d = trg_sync_q[1];
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         trg_sync_q <= 2'h0;
         clr_sync_q <= 2'h0;
         trg_prev_q <= 1'b0;
      end else begin
         trg_sync_q <= trg_sync_d;
         clr_sync_q <= clr_sync_d;
         trg_prev_q <= trg_prev_d;
      end
   end

   assign trg_rise = trg_sync_q[1] & ~trg_prev_q;
   assign clr_lvl  = clr_sync_q[1];

   // Edge only counts when idle and not held in clear
   assign start = trg_rise & ~clr_lvl
                & (state_q == single_pulse_pkg::ST_IDLE);

   // Timebase is realigned on each start, so the pulse is cycle-exact
   pulse_timebase #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_timebase (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_restart (start),
      .o_tick    (tick)
   );

   // Pulse sequencing: hundredths counted down, each worth mult ticks
   always_comb begin
      state_d  = state_q;
      remain_d = remain_q;
      sub_d    = sub_q;
      mult_d   = mult_q;
      pulse_d  = pulse_q;
      if (clr_lvl) begin
         state_d  = single_pulse_pkg::ST_IDLE;
         remain_d = '0;
         sub_d    = '0;
         pulse_d  = 1'b0;
      end else begin
         unique case (state_q)
            single_pulse_pkg::ST_IDLE: begin
               if (start) begin
                  state_d  = single_pulse_pkg::ST_PULSE;
                  remain_d = clamp_dur(i_duration);
                  mult_d   = unit_mult(i_unit);
                  sub_d    = unit_mult(i_unit) - 1'b1;
                  pulse_d  = 1'b1;
               end
            end
            single_pulse_pkg::ST_PULSE: begin
               // Further edges fall through untouched here
               if (tick) begin
                  if (sub_q != '0) begin
                     sub_d = sub_q - 1'b1;
                  end else if (remain_q == single_pulse_pkg::DUR_MIN) begin
                     state_d  = single_pulse_pkg::ST_IDLE;
                     remain_d = '0;
                     pulse_d  = 1'b0;
                  end else begin
                     remain_d = remain_q - 1'b1;
                     sub_d    = mult_q - 1'b1;
                  end
               end
            end
            default: begin
               state_d = single_pulse_pkg::ST_IDLE;
               pulse_d = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         state_q  <= single_pulse_pkg::ST_IDLE;
         remain_q <= '0;
         sub_q    <= '0;
         mult_q   <= single_pulse_pkg::MULT_SEC;
         pulse_q  <= 1'b0;
      end else begin
         state_q  <= state_d;
         remain_q <= remain_d;
         sub_q    <= sub_d;
         mult_q   <= mult_d;
         pulse_q  <= pulse_d;
      end
   end

   // Both outputs from flops; busy mirrors the state bit
   assign o_pulse = pulse_q;
   assign o_busy  = state_q[1];

endmodule : single_pulse_relay_block

//--- tb/single_pulse_properties.sv
module single_pulse_properties #(
   parameter int TICK_CYCLES = single_pulse_pkg::BASE_TICK_CYC
) (
   input wire logic        i_clk,
   input wire logic        i_reset_n,
   input wire logic        i_pulse_trigger,
   input wire logic        i_clear,
   input wire logic [13:0] i_duration,
   input wire logic [1:0]  i_unit,
   input wire logic        o_pulse,
   input wire logic        o_busy
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   longint cnt_q;
   longint exp_q;
   // Clamped length; 64 bits since hour settings overflow int
   function automatic longint len_of(logic [13:0] d, logic [1:0] u);
      longint n;
      n = (d == 14'h0) ? 1 : (d > 14'h270f) ? 9999 : longint'(d);
      return n * (u == 2'h1 ? 60 : u == 2'h2 ? 3600 : 1) * TICK_CYCLES;
   endfunction : len_of
   // High cycles so far, target latched while idle
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         cnt_q <= 0;
         exp_q <= 0;
      end else begin
         cnt_q <= o_pulse ? cnt_q + 1 : 0;
         exp_q <= o_pulse ? exp_q : len_of(i_duration, i_unit);
      end
   end
   chk_start_delay: assert property (
      $rose(i_pulse_trigger) && !i_clear && !o_pulse ##1 !o_pulse[*2]
      |=> o_pulse) else $error("pulse did not start");
   chk_exact_length: assert property (
      $fell(o_pulse) && !$past(i_clear, 3) |-> cnt_q == exp_q)
      else $error("pulse length wrong");
   chk_no_extend: assert property (
      o_pulse |-> cnt_q < exp_q) else $error("pulse extended");
   chk_clear_drops: assert property (
      i_clear |-> ##3 !o_pulse) else $error("clear ignored");
   chk_clear_wins: assert property (
      i_clear ##1 $rose(i_pulse_trigger) |-> ##2 !$rose(o_pulse))
      else $error("trigger won over clear");
   chk_busy_follows: assert property (
      o_busy == o_pulse) else $error("busy differs");
   chk_reset_low: assert property (
      disable iff (1'b0) !i_reset_n |=> !o_pulse && !o_busy)
      else $error("output high in reset");
   cover property ($rose(o_pulse));
   cover property ($fell(o_pulse) && $past(i_clear, 3));
   cover property (o_pulse && $rose(i_pulse_trigger));
endmodule : single_pulse_properties

bind single_pulse_relay_block single_pulse_properties #(
   .TICK_CYCLES(TICK_CYCLES)) u_props (.i_clk(i_clk),
   .i_reset_n(i_reset_n), .i_pulse_trigger(i_pulse_trigger),
   .i_clear(i_clear), .i_duration(i_duration), .i_unit(i_unit),
   .o_pulse(o_pulse), .o_busy(o_busy));

//--- tb/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [13:0] d; logic [1:0] u; int len;} row_t;
   logic        i_clk, i_reset_n, i_pulse_trigger, i_clear, o_pulse, o_busy;
   logic [13:0] i_duration;
   logic [1:0]  i_unit;
   int          bad_count = 0;
   int          samples_checked = 0;
   int          n;
   row_t        rows[7];
   single_pulse_relay_block #(.TICK_CYCLES(4)) u_single_pulse_relay_block (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_pulse_trigger(i_pulse_trigger),
      .i_clear(i_clear), .i_duration(i_duration), .i_unit(i_unit),
      .o_pulse(o_pulse), .o_busy(o_busy));
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   task automatic end_of_test();
      $display("checked %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_of_test
   task automatic check_len(input string what, input int exp, input int got);
      samples_checked++;
      if (got != exp) begin
         bad_count++;
         $display("mismatch %s expected %0d seen %0d", what, exp, got);
      end
   endtask : check_len
   task automatic check_bit(input string what, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask : check_bit
   // One pulse; optional re-trigger while high, which must not extend it
   task automatic fire(input logic [13:0] d, input logic [1:0] u,
                       input bit rt, output int len);
      int w;
      w = 0;
      len = 0;
      @(posedge i_clk);
      i_duration <= d;
      i_unit <= u;
      i_pulse_trigger <= 1'b1;
      // Outputs looked at just after the edge, once settled
      #1;
      while (o_pulse !== 1'b1 && w < 10) begin
         @(posedge i_clk);
         #1;
         w++;
      end
      check_len("start delay", 3, w);
      check_bit("busy at start", 1'b1, o_busy);
      while (o_pulse === 1'b1 && len < 50000) begin
         len++;
         @(posedge i_clk);
         if (rt && len == 3) i_pulse_trigger <= 1'b0;
         if (rt && len == 5) i_pulse_trigger <= 1'b1;
         #1;
      end
      check_bit("busy at end", 1'b0, o_busy);
      @(posedge i_clk);
      i_pulse_trigger <= 1'b0;
   endtask : fire
   // Run is about 55k cycles; give it headroom
   initial begin
      repeat (80000) @(posedge i_clk);
      bad_count++;
      end_of_test();
   end
   initial begin
      {i_reset_n, i_pulse_trigger, i_clear} = 3'h0;
      i_duration = 14'h0001;
      i_unit = 2'h0;
      rows = '{'{14'h0001, 2'h0, 4}, '{14'h0003, 2'h0, 12},
               '{14'h0001, 2'h1, 240}, '{14'h0001, 2'h2, 14400},
               '{14'h0000, 2'h0, 4}, '{14'h0002, 2'h3, 8},
               '{14'h2710, 2'h0, 39996}};
      repeat (6) @(posedge i_clk);
      i_reset_n <= 1'b1;
      repeat (2) @(posedge i_clk);
      foreach (rows[k]) begin
         fire(rows[k].d, rows[k].u, 1'b0, n);
         check_len("length", rows[k].len, n);
         $display("row %0d done", k);
      end
      fire(14'h0003, 2'h0, 1'b1, n);
      check_len("retrigger length", 12, n);
      $display("retrigger test done");
      @(posedge i_clk);
      i_duration <= 14'h0005;
      i_pulse_trigger <= 1'b1;
      repeat (8) @(posedge i_clk);
      check_bit("pulse before clear", 1'b1, o_pulse);
      i_clear <= 1'b1;
      repeat (4) @(posedge i_clk);
      check_bit("clear", 1'b0, o_pulse);
      i_pulse_trigger <= 1'b0;
      @(posedge i_clk) i_pulse_trigger <= 1'b1;
      repeat (6) @(posedge i_clk);
      check_bit("trigger in clear", 1'b0, o_pulse);
      {i_clear, i_pulse_trigger} <= 2'h0;
      repeat (4) @(posedge i_clk);
      fire(14'h0002, 2'h0, 1'b0, n);
      check_len("after clear", 8, n);
      $display("clear tests done");
      @(posedge i_clk);
      i_pulse_trigger <= 1'b1;
      repeat (8) @(posedge i_clk);
      check_bit("pulse before reset", 1'b1, o_pulse);
      i_reset_n <= 1'b0;
      repeat (2) @(posedge i_clk);
      check_bit("reset", 1'b0, o_pulse);
      check_bit("reset busy", 1'b0, o_busy);
      {i_reset_n, i_pulse_trigger} <= 2'h2;
      $display("reset test done");
      end_of_test();
   end
endmodule : testbench
